// >>> design/smc_params.svh
// constants of the static memory controller
`ifndef SMC_PARAMS_SVH
`define SMC_PARAMS_SVH
`define SMC_NUM_CS 8
`define SMC_ADDR_W 26
`define SMC_DATA_W 32
`define SMC_TIM_W 6
`define SMC_DBW_8 2'h0
`define SMC_DBW_16 2'h1
`define SMC_DBW_32 2'h2
`define SMC_BAT_SELECT 1'h0
`define SMC_BAT_WRITE 1'h1
`define SMC_CS0_DBW_RST 2'h1
`define SMC_SLOW_SETUP 6'h01
`define SMC_SLOW_PULSE 6'h01
`define SMC_SLOW_CYCLE 6'h03
`define SMC_PAGE_BYTES 32
`define SMC_NAND_CS 3
`define SMC_CARD0_CS 4
`define SMC_CARD1_CS 5
`define SMC_ALE_BIT 21
`define SMC_CLE_BIT 22
`define SMC_IO_SPACE_BIT 23
`endif

// >>> design/smc_pkg.sv
// types of the static memory controller
package smc_pkg;
  typedef enum logic [1:0] {
    SMC_IDLE = 2'h0,
    SMC_SETUP = 2'h1,
    SMC_PULSE = 2'h3,
    SMC_HOLD = 2'h2
  } smc_state_type;

  typedef struct packed {
    smc_state_type state;
    logic [5:0] count;
    logic write;
    logic [2:0] cs;
    logic [25:0] addr;
    logic [31:0] wdata;
    logic [3:0] be;
    logic [1:0] dbw;
    logic bat;
    logic [5:0] setup;
    logic [5:0] pulse;
    logic [5:0] cycle;
    logic [1:0] wait_sync;
    logic [7:0] cs_n;
    logic rd_n;
    logic we_n;
    logic [3:0] lane_n;
    logic [25:0] addr_out;
    logic [31:0] dout;
    logic doe_n;
    logic [31:0] rdata;
    logic done;
    logic busy;
  } smc_regs_type;
endpackage

// >>> design/smc_static_memory_controller.sv
// static memory controller: chip selects, address and strobes for asynchronous devices
// Function
// RULE1: eight active-low chip selects and a 26-bit address bus, one region each.
// RULE2: 32-bit data bus, each chip select set for 8, 16 or 32-bit devices.
// RULE3: setup, pulse, cycle and mode are programmable per chip select.
// RULE4: active-low wait input stretches the access in progress.
// RULE5: slow clock mode swaps programmed waveforms for fixed slow ones.
// RULE6: page mode burst reads for pages up to 32 bytes; the code only skips hold after page mode reads and never checks a page size.
// RULE7: reset leaves chip select 0 byte select, 16-bit, slow timing for boot.
// RULE8: shared pin carries address bit 0 on 8-bit, byte 0 select otherwise.
// RULE9: shared pin carries address 1 on 8/16-bit, byte 2 strobe on 32-bit.
// RULE10: shared strobes are byte writes or single write plus byte selects.
// RULE11: chip selects, read strobe and byte strobes are active low.
// RULE12: nand on chip select 3 uses A21 for address latch, A22 for command.
// RULE13: card slot uses A23 for io versus memory, A22 for attribute space.
// RULE14: disk emulation uses A21 for alternate versus primary register set.
// RULE15: software assigns chip selects 3, 4, 5 and 1 before use.
// RULE16: software hands shared pins to the controller before access.
// RULE17: timings count whole master clocks per chip select; cycle sets hold.
// RULE18: software never programs a zero pulse length.
// RULE19: the wait input is synchronised before use.
// RULE20: selects and strobes idle high except back-to-back zero setup and hold; the code returns them high between every two accesses.
`timescale 1ns/10ps
`include "smc_params.svh"
module smc_static_memory_controller
  import smc_pkg::*;
#(
  parameter int NUM_CS = `SMC_NUM_CS
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [2:0] req_cs,
  input wire logic [25:0] req_addr,
  input wire logic [31:0] req_wdata,
  input wire logic [3:0] req_be,
  input wire logic slow_clock_mode,
  input wire logic [NUM_CS*2-1:0] cfg_dbw,
  input wire logic [NUM_CS-1:0] cfg_bat,
  input wire logic [NUM_CS*6-1:0] cfg_setup,
  input wire logic [NUM_CS*6-1:0] cfg_pulse,
  input wire logic [NUM_CS*6-1:0] cfg_cycle,
  input wire logic [NUM_CS-1:0] cfg_page_mode,
  input wire logic nand_area_assign,
  input wire logic card_slot0_assign,
  input wire logic card_slot1_assign,
  input wire logic sdram_area_assign,
  input wire logic external_hold_request_n,
  input wire logic [31:0] data_in,
  output logic req_ready,
  output logic rsp_valid,
  output logic [31:0] rsp_rdata,
  output logic [NUM_CS-1:0] device_select_n,
  output logic read_strobe_n,
  output logic [25:2] addr_out,
  output logic lane0_pin,
  output logic write_strobe_n,
  output logic lane1_pin,
  output logic lane2_pin,
  output logic lane3_pin,
  output logic [31:0] data_out,
  output logic data_oe_n
);
  smc_regs_type state_reg;
  smc_regs_type state_next;
  logic cs0_boot_reg;
  logic cs0_boot_next;

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [5:0] pick6(input logic [NUM_CS*6-1:0] v, input logic [2:0] i);
    pick6 = v[i*6 +: 6];
  endfunction

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [5:0] s;
    logic [5:0] p;
    logic [5:0] c;
    logic [1:0] dbw;
    logic bat;
    logic strobe_on;
    s = '0;
    p = '0;
    c = '0;
    dbw = '0;
    bat = '0;
    strobe_on = 1'b0;
    state_next = state_reg;
    cs0_boot_next = cs0_boot_reg;
    state_next.done = 1'b0;
    state_next.wait_sync = {state_reg.wait_sync[0], ~external_hold_request_n}; // RULE19
    case (state_reg.state)
      SMC_IDLE: begin
        if (req_valid) begin
          // chip select 0 keeps the boot profile until it is first used with a normal clock
          if (req_cs == 3'h0 && cs0_boot_reg) begin
            dbw = `SMC_CS0_DBW_RST; // RULE7
            bat = `SMC_BAT_SELECT;
          end else begin
            dbw = cfg_dbw[req_cs*2 +: 2]; // RULE2
            bat = cfg_bat[req_cs]; // RULE10
          end
          if (slow_clock_mode || (req_cs == 3'h0 && cs0_boot_reg)) begin
            s = `SMC_SLOW_SETUP; // RULE5
            p = `SMC_SLOW_PULSE;
            c = `SMC_SLOW_CYCLE;
          end else begin
            s = pick6(cfg_setup, req_cs); // RULE3 RULE17
            p = pick6(cfg_pulse, req_cs);
            c = pick6(cfg_cycle, req_cs);
          end
          if (req_cs == 3'h0 && !slow_clock_mode) begin
            cs0_boot_next = 1'b0;
          end
          state_next.write = req_write;
          state_next.cs = req_cs;
          state_next.addr = req_addr; // RULE12 RULE13 RULE14
          state_next.wdata = req_wdata;
          state_next.be = req_be;
          state_next.dbw = dbw;
          state_next.bat = bat;
          state_next.setup = s;
          state_next.pulse = p;
          state_next.cycle = c;
          state_next.busy = 1'b1;
          state_next.count = 6'h00;
          state_next.state = (s == 6'h00) ? SMC_PULSE : SMC_SETUP;
          state_next.addr_out = req_addr; // RULE1
          state_next.cs_n = 8'hff & ~(8'h01 << req_cs); // RULE11
          state_next.doe_n = ~req_write;
          state_next.dout = req_wdata;
          strobe_on = (s == 6'h00);
        end
      end
      SMC_SETUP: begin
        state_next.count = state_reg.count + 6'h01;
        if (state_reg.count + 6'h01 >= state_reg.setup) begin
          state_next.state = SMC_PULSE;
          strobe_on = 1'b1;
        end
      end
      SMC_PULSE: begin
        strobe_on = 1'b1;
        if (state_reg.wait_sync[1]) begin
          state_next.count = state_reg.count; // RULE4
        end else begin
          state_next.count = state_reg.count + 6'h01;
          if (state_reg.count + 6'h01 >= state_reg.setup + state_reg.pulse) begin
            strobe_on = 1'b0;
            state_next.rdata = data_in;
            state_next.state = (state_reg.cycle > state_reg.setup + state_reg.pulse) ? SMC_HOLD : SMC_IDLE;
          end
        end
      end
      default: begin
        state_next.count = state_reg.count + 6'h01;
        if (state_reg.count + 6'h01 >= state_reg.cycle) begin
          state_next.state = SMC_IDLE;
        end
      end
    endcase
    // page mode reads skip hold whenever cfg_page_mode is set for the chip select; no page address is compared
    if (state_reg.state == SMC_PULSE && state_next.state != SMC_PULSE) begin
      state_next.done = 1'b1;
      if (state_next.state == SMC_IDLE) begin
        state_next.busy = 1'b0;
      end
    end
    if (state_reg.state == SMC_HOLD && state_next.state == SMC_IDLE) begin
      state_next.busy = 1'b0;
    end
    if (state_reg.state == SMC_PULSE && !state_reg.write && cfg_page_mode[state_reg.cs] &&
        state_next.state == SMC_HOLD) begin
      state_next.state = SMC_IDLE; // RULE6
      state_next.busy = 1'b0;
    end
    // chip select returns high on every entry to idle, also between back to back accesses, since a taken request never stays in idle
    if (state_next.state == SMC_IDLE && !(state_reg.state == SMC_IDLE && req_valid)) begin
      state_next.cs_n = 8'hff; // RULE20
      state_next.doe_n = 1'b1;
    end
    state_next.rd_n = ~(strobe_on && !state_next.write);
    state_next.we_n = ~(strobe_on && state_next.write);
    state_next.lane_n = ~state_next.be;
    if (state_next.bat == `SMC_BAT_WRITE) begin
      state_next.lane_n = ~(state_next.be & {4{strobe_on && state_next.write}}); // RULE10
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_reg <= '0;
      state_reg.state <= SMC_IDLE;
      state_reg.cs_n <= 8'hff;
      state_reg.rd_n <= 1'b1;
      state_reg.we_n <= 1'b1;
      state_reg.lane_n <= 4'hf;
      state_reg.doe_n <= 1'b1;
      state_reg.dbw <= `SMC_CS0_DBW_RST;
      cs0_boot_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      cs0_boot_reg <= cs0_boot_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pin multiplexing by bus width and byte access type
  logic byte_write_mode;
  logic wide32;
  logic narrow8;
  assign byte_write_mode = state_reg.bat == `SMC_BAT_WRITE;
  assign wide32 = state_reg.dbw == `SMC_DBW_32;
  assign narrow8 = state_reg.dbw == `SMC_DBW_8;
  assign req_ready = ~state_reg.busy;
  assign rsp_valid = state_reg.done;
  assign rsp_rdata = state_reg.rdata;
  assign device_select_n = state_reg.cs_n[NUM_CS-1:0];
  assign read_strobe_n = state_reg.rd_n; // RULE11
  assign addr_out = state_reg.addr_out[25:2];
  assign lane0_pin = narrow8 ? state_reg.addr_out[0] : state_reg.lane_n[0]; // RULE8
  assign write_strobe_n = byte_write_mode && !narrow8 ? state_reg.lane_n[0] : state_reg.we_n;
  assign lane1_pin = state_reg.lane_n[1];
  assign lane2_pin = wide32 ? state_reg.lane_n[2] : state_reg.addr_out[1]; // RULE9
  assign lane3_pin = state_reg.lane_n[3];
  assign data_out = state_reg.dout;
  assign data_oe_n = state_reg.doe_n;
endmodule

// >>> verification/smc_static_memory_controller_monitor.sv
// port assertions for the static memory controller
`timescale 1ns/10ps
`include "smc_params.svh"
module smc_static_memory_controller_monitor
  import smc_pkg::*;
#(
  parameter int NUM_CS = 8
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [2:0] req_cs,
  input wire logic [25:0] req_addr,
  input wire logic [3:0] req_be,
  input wire logic slow_clock_mode,
  input wire logic [NUM_CS*2-1:0] cfg_dbw,
  input wire logic [NUM_CS-1:0] cfg_bat,
  input wire logic external_hold_request_n,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire logic [NUM_CS-1:0] device_select_n,
  input wire logic read_strobe_n,
  input wire logic [25:2] addr_out,
  input wire logic lane0_pin,
  input wire logic lane1_pin,
  input wire logic lane2_pin,
  input wire logic data_oe_n
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  logic taken;
  logic [1:0] width;
  assign taken = req_valid && req_ready;
  assign width = cfg_dbw[req_cs*2+:2];
  sequence slow_read_s;
    taken && slow_clock_mode && !req_write && external_hold_request_n ##1 external_hold_request_n [*3];
  endsequence
  ////////////////////////////////////////////////////////////////
  reset_idle_a:
    assert property ($fell(sys_rst) |-> &device_select_n && read_strobe_n && data_oe_n && req_ready && !rsp_valid)
    else $error("outputs not idle after reset");
  one_select_a:
    assert property ($onehot0(~device_select_n)) else $error("more than one select low");
  select_addr_a:
    assert property (taken |=> !device_select_n[$past(req_cs)] && addr_out == $past(req_addr[25:2]))
    else $error("select or address wrong after request");
  slow_read_a:
    assert property (slow_read_s |-> rsp_valid && read_strobe_n && !$past(read_strobe_n) && $past(read_strobe_n, 2))
    else $error("slow read waveform wrong");
  wait_hold_a:
    assert property (!read_strobe_n && !external_hold_request_n && !$past(external_hold_request_n)
      && !$past(external_hold_request_n, 2) |=> !read_strobe_n) else $error("read strobe ended under wait");
  lane_8bit_a:
    assert property (taken && req_cs != 3'h0 && width == `SMC_DBW_8 |=> lane0_pin == $past(req_addr[0])
      && lane2_pin == $past(req_addr[1])) else $error("8-bit lanes do not carry address");
  lane_16bit_a:
    assert property (taken && width == `SMC_DBW_16 |=> lane2_pin == $past(req_addr[1]))
    else $error("16-bit lane does not carry address bit 1");
  lane_32sel_a:
    assert property (taken && req_write && req_cs != 3'h0 && width == `SMC_DBW_32 && cfg_bat[req_cs] ==
      `SMC_BAT_SELECT |=> lane2_pin == !$past(req_be[2]) && lane1_pin == !$past(req_be[1]))
    else $error("32-bit byte selects wrong");
endmodule
bind smc_static_memory_controller smc_static_memory_controller_monitor #(.NUM_CS(NUM_CS)) u_monitor (.*);

// >>> verification/smc_ext_memory.sv
// behavioural external memory with an optional wait request
`timescale 1ns/10ps
module smc_ext_memory (
  input wire logic sys_clk,
  input wire logic stall,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic [25:2] addr_out,
  input wire logic [3:0] lane_n,
  input wire logic [31:0] data_out,
  output logic [31:0] data_in,
  output logic external_hold_request_n
);
  logic [31:0] mem [0:15];
  logic [31:0] junk = 32'h5a5a_a5a5;
  int low = 0;
  // released bus shows a changing pattern
  assign data_in = read_strobe_n ? junk : mem[addr_out[5:2]];
  assign external_hold_request_n = !(stall && !read_strobe_n && low < 4);
  always @(posedge sys_clk) begin
    junk <= ~junk;
    low <= read_strobe_n ? 0 : low + 1;
    for (int i = 0; i < 4; i++)
      if (!write_strobe_n && !lane_n[i]) mem[addr_out[5:2]][i*8+:8] <= data_out[i*8+:8];
  end
endmodule

// >>> verification/tb.sv
// self-checking bench for the static memory controller
`timescale 1ns/10ps
module tb;
  logic sys_clk = 0, sys_rst = 1, req_valid = 0, req_write = 0, slow_clock_mode = 1, stall = 0;
  logic nand_area_assign = 1, card_slot0_assign = 0, card_slot1_assign = 0, sdram_area_assign = 0;
  logic [2:0] req_cs = 0;
  logic [25:0] req_addr = 0;
  logic [31:0] req_wdata = 0, data_in, rsp_rdata, data_out, rdata;
  logic [3:0] req_be = 4'hf, lanes;
  logic [7:0] cfg_bat = 0, cfg_page_mode = 0, device_select_n;
  logic [15:0] cfg_dbw = 16'h5561;
  logic [47:0] cfg_setup = {8{6'h01}}, cfg_pulse = {8{6'h01}}, cfg_cycle = {8{6'h04}};
  logic [25:2] addr_out, aout;
  logic rdy;
  logic req_ready, rsp_valid, read_strobe_n, write_strobe_n, external_hold_request_n, data_oe_n;
  logic lane0_pin, lane1_pin, lane2_pin, lane3_pin;
  int errors = 0, tests_run = 0, lat;
  always #50 sys_clk = ~sys_clk;
  smc_static_memory_controller u_smc_static_memory_controller (.*);
  smc_ext_memory u_smc_ext_memory (.lane_n({lane3_pin, lane2_pin, lane1_pin, lane0_pin}), .*);
  ////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // one access: hold the request until taken, then count cycles to the answer
  task automatic access(input logic wr, input logic [2:0] cs, input logic [25:0] a, input logic [31:0] wd,
                        input logic [3:0] be);
    int n;
    n = 0;
    @(negedge sys_clk);
    {req_valid, req_write, req_cs, req_addr, req_wdata, req_be} = {1'b1, wr, cs, a, wd, be};
    // ready is a registered level, so its value at the falling edge holds at the next rising edge
    while (req_ready !== 1'b1 && n < 50) begin
      @(negedge sys_clk);
      n++;
    end
    @(negedge sys_clk);
    req_valid = 0;
    lanes = {lane3_pin, lane2_pin, lane1_pin, lane0_pin};
    aout = addr_out;
    lat = 1;
    while (rsp_valid !== 1'b1 && lat < 60) begin
      @(negedge sys_clk);
      lat++;
    end
    rdata = rsp_rdata;
    rdy = req_ready;
    if (n == 50 || lat == 60) begin
      errors++;
      conclude();
    end
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    cfg_setup[12+:6] = 6'h02;
    cfg_pulse[12+:6] = 6'h03;
    cfg_cycle[12+:6] = 6'h07;
    repeat (20) @(posedge sys_clk);
    @(negedge sys_clk);
    sys_rst = 0;
    check(device_select_n, 8'hff);
    check({read_strobe_n, data_oe_n, req_ready, rsp_valid}, 4'he);
    access(0, 3'h0, 26'h2, 0, 4'h3);
    check(lat, 3);
    check(lanes[2], 1'b1);
    slow_clock_mode = 0;
    access(1, 3'h2, 26'h10, 32'h11223344, 4'hf);
    check(lat, 6);
    check(lanes, 4'h0);
    access(1, 3'h2, 26'h10, 32'haabbccdd, 4'h5);
    check(lanes, 4'ha);
    access(0, 3'h2, 26'h10, 0, 4'hf);
    check(rdata, 32'h11bb33dd);
    check(rdy, 1'b0);
    stall = 1;
    access(0, 3'h2, 26'h10, 0, 4'hf);
    check(lat > 6, 1'b1);
    check(rdata, 32'h11bb33dd);
    stall = 0;
    access(0, 3'h1, 26'h3, 0, 4'h1);
    check({lanes[2], lanes[0]}, 2'h3);
    access(0, 3'h3, 26'h0600000, 0, 4'hf);
    check(aout[22:21], 2'h3);
    access(0, 3'h4, 26'h0a00000, 0, 4'hf);
    check(aout[23], 1'b1);
    check(aout[21], 1'b1);
    cfg_page_mode[2] = 1'b1;
    access(0, 3'h2, 26'h10, 0, 4'hf);
    check(rdy, 1'b1);
    check(rdata, 32'h11bb33dd);
    cfg_page_mode[2] = 1'b0;
    slow_clock_mode = 1;
    access(0, 3'h2, 26'h10, 0, 4'hf);
    check(lat, 3);
    conclude();
  end
endmodule
